// File: hw/ecc_status_consts.svh
// Offsets, field positions, reset values and widths of the ECC status registers
`ifndef ECC_STATUS_CONSTS_SVH
`define ECC_STATUS_CONSTS_SVH

// ****************************************
// Register word offsets
// ****************************************
`define OFS_DBE_ADDR 4'h6
`define OFS_SBE_DATA 4'h7
`define OFS_SBE_SYND 4'h8
`define OFS_DBE_DATA 4'h9
`define OFS_IRQ_STAT 4'hA
`define OFS_IRQ_MASK 4'hB
`define OFS_SBE_LOC 4'hC
`define OFS_DBE_LOC 4'hD

// ****************************************
// Interrupt status and mask fields
// ****************************************
`define IRQ_SBE 0
`define IRQ_DBE 1
`define IRQ_SBE_LIMIT 2
`define IRQ_DBE_LIMIT 3
`define IRQ_DBE_RMW 4

// ****************************************
// Reset values and widths
// ****************************************
`define RST_WORD 32'h0000_0000
`define RST_IRQ_STAT 5'h00
`define RST_IRQ_MASK 5'h01
`define IRQ_BITS 5
`define PART_BITS 64
`define SYND_BITS 8
`define PIECE_BITS 32

`endif

// File: hw/ecc_status_pkg.sv
// Types shared by the ECC status register files
package ecc_status_pkg;
  // Control port word
  typedef logic [31:0] word_t;
  // Control port word address
  typedef logic [3:0] reg_addr_t;
  // Interrupt status or mask vector
  typedef logic [4:0] irq_vec_t;
endpackage

// File: hw/ecc_status_regs.sv
// ECC error status, capture stores and interrupt registers on the control port
`timescale 1ns/1ns
`include "ecc_status_consts.svh"
module ecc_status_regs #(
  parameter int N = 2 // 64-bit parts per data word
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control slave port, word addressed, one-cycle read latency
  input wire ecc_status_pkg::reg_addr_t address,
  input wire logic read,
  input wire logic write,
  input wire ecc_status_pkg::word_t writedata,
  output ecc_status_pkg::word_t readdata,
  output logic readdatavalid,
  // Control word bits
  input wire logic keep_first_err,
  input wire logic clear_status,
  input wire logic clear_irq,
  input wire logic clear_sbe_data,
  input wire logic clear_dbe_data,
  input wire logic clear_syndrome,
  // Error reports from the decoder
  input wire logic err_valid,
  input wire ecc_status_pkg::word_t err_addr,
  input wire logic [N*64-1:0] err_data,
  input wire logic [N*8-1:0] err_syndromes,
  input wire logic [N-1:0] sbe_parts,
  input wire logic [N-1:0] dbe_parts,
  input wire logic err_in_rmw,
  input wire logic sbe_limit_hit,
  input wire logic dbe_limit_hit,
  // Interrupt
  output logic irq
);
  import ecc_status_pkg::*;

  // ****************************************
  // Sizes and checks
  // ****************************************
  localparam int PIECES = N * `PART_BITS / `PIECE_BITS; // 32-bit pieces per word
  localparam int PW = $clog2(PIECES); // Piece pointer width
  localparam int SW = (N > 1) ? $clog2(N) : 1; // Syndrome index width

  // Refuse part counts that the location reads cannot hold
  // A 32-bit location word carries one flag per part, at most 32
  if (N < 1 || N > 32)
  begin : g_bad_n
    $error("ecc_status_regs: N must lie between 1 and 32");
  end

  // Step a piece pointer with wrap
  function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
    if (p == PW'(PIECES - 1))
      return '0;
    else
      return p + PW'(1);
  endfunction

  // Widen a narrow field into a word
  function automatic word_t widen(input logic [31:0] v, input int bits);
    word_t m;
    m = (bits >= 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << bits) - 32'h0000_0001);
    return v & m;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  // Stores
  word_store_if #(.WORDS(PIECES), .WIDTH(`PIECE_BITS)) sbe_if();
  word_store_if #(.WORDS(PIECES), .WIDTH(`PIECE_BITS)) dbe_if();
  word_store_if #(.WORDS(N), .WIDTH(`SYND_BITS)) syn_if();

  // Decoded accesses
  logic rd_sbe_data; // Read pops a single-bit data piece
  logic rd_dbe_data; // Read pops a double-bit data piece
  logic wr_stat; // Write-one-clear of interrupt status
  logic wr_mask; // Write of interrupt mask
  logic wr_sbe_loc; // Write-one-clear of single-bit locations
  logic wr_dbe_loc; // Write-one-clear of double-bit locations

  // Events
  logic sbe_evt; // Some part had a single-bit error
  logic dbe_evt; // Some part had a double-bit error

  // Registers
  word_t dbe_addr_ff, nxt_dbe_addr; // Captured double-bit address
  logic addr_held_ff, nxt_addr_held; // First address already taken
  logic [PW-1:0] sbe_ptr_ff, nxt_sbe_ptr; // Single-bit piece shown
  logic [PW-1:0] dbe_ptr_ff, nxt_dbe_ptr; // Double-bit piece shown
  irq_vec_t mask_ff, nxt_mask; // Interrupt mask
  word_t rdata_ff, nxt_rdata; // Read answer
  logic rvalid_ff, nxt_rvalid; // Read answer strobe
  logic irq_ff, nxt_irq; // Interrupt line

  // Sticky bit sets, clears and values
  irq_vec_t stat_set, stat_clr, stat_q;
  logic [N-1:0] sloc_clr, sloc_q;
  logic [N-1:0] dloc_clr, dloc_q;

  // ****************************************
  // Access decode and events
  // ****************************************
  always_comb
  begin
    rd_sbe_data = read && (address == `OFS_SBE_DATA);
    rd_dbe_data = read && (address == `OFS_DBE_DATA);
    wr_stat = write && (address == `OFS_IRQ_STAT);
    wr_mask = write && (address == `OFS_IRQ_MASK);
    wr_sbe_loc = write && (address == `OFS_SBE_LOC);
    wr_dbe_loc = write && (address == `OFS_DBE_LOC);
    sbe_evt = err_valid && (|sbe_parts);
    dbe_evt = err_valid && (|dbe_parts);
  end

  // ****************************************
  // Interrupt status, bit order by cause
  // ****************************************
  always_comb
  begin
    stat_set = '0;
    stat_set[`IRQ_SBE] = sbe_evt;
    stat_set[`IRQ_DBE] = dbe_evt;
    stat_set[`IRQ_SBE_LIMIT] = sbe_limit_hit;
    stat_set[`IRQ_DBE_LIMIT] = dbe_limit_hit;
    stat_set[`IRQ_DBE_RMW] = dbe_evt && err_in_rmw;
    // Ones written clear, clear-interrupt command clears all
    // A cause that fires in the same cycle still sets its bit
    stat_clr = (wr_stat ? writedata[`IRQ_BITS-1:0] : '0) | {`IRQ_BITS{clear_irq}};
    sloc_clr = wr_sbe_loc ? writedata[N-1:0] : '0;
    dloc_clr = wr_dbe_loc ? writedata[N-1:0] : '0;
  end

  // Interrupt status bits
  sticky_bits #(.W(`IRQ_BITS)) u_stat (
    .clk(clk),
    .rst_n(rst_n),
    .set(stat_set),
    .clr(stat_clr),
    .q(stat_q)
  );

  // Single-bit location bits, one per part
  sticky_bits #(.W(N)) u_sloc (
    .clk(clk),
    .rst_n(rst_n),
    .set(err_valid ? sbe_parts : '0),
    .clr(sloc_clr),
    .q(sloc_q)
  );

  // Double-bit location bits, one per part
  sticky_bits #(.W(N)) u_dloc (
    .clk(clk),
    .rst_n(rst_n),
    .set(err_valid ? dbe_parts : '0),
    .clr(dloc_clr),
    .q(dloc_q)
  );

  // ****************************************
  // Captured data and syndrome stores
  // ****************************************
  always_comb
  begin
    // Latest single-bit word, lowest piece as word 0
    sbe_if.load = sbe_evt;
    sbe_if.clear = clear_sbe_data;
    sbe_if.wdata = err_data;
    sbe_if.idx = nxt_sbe_ptr;
    // Latest double-bit word, lowest piece as word 0
    dbe_if.load = dbe_evt;
    dbe_if.clear = clear_dbe_data;
    dbe_if.wdata = err_data;
    dbe_if.idx = nxt_dbe_ptr;
    // Syndromes, one byte per part
    syn_if.load = sbe_evt;
    syn_if.clear = clear_syndrome;
    syn_if.wdata = err_syndromes;
    // Two pieces per part: part index is the piece pointer halved
    // The index follows the next pointer so the byte is ready with its piece
    syn_if.idx = SW'(nxt_sbe_ptr >> 1);
  end

  // Single-bit data store
  word_store #(.WORDS(PIECES), .WIDTH(`PIECE_BITS)) u_sbe_data (
    .clk(clk),
    .rst_n(rst_n),
    .sp(sbe_if.store)
  );

  // Double-bit data store
  word_store #(.WORDS(PIECES), .WIDTH(`PIECE_BITS)) u_dbe_data (
    .clk(clk),
    .rst_n(rst_n),
    .sp(dbe_if.store)
  );

  // Syndrome store
  word_store #(.WORDS(N), .WIDTH(`SYND_BITS)) u_synd (
    .clk(clk),
    .rst_n(rst_n),
    .sp(syn_if.store)
  );

  // ****************************************
  // Next values of the register group
  // ****************************************
  always_comb
  begin
    // Double-bit address capture
    nxt_dbe_addr = dbe_addr_ff;
    nxt_addr_held = addr_held_ff;
    // Clear beats a capture in the same cycle
    if (clear_status)
    begin
      // Clear command zeroes address and rearms first capture
      nxt_dbe_addr = `RST_WORD;
      nxt_addr_held = 1'b0;
    end
    else if (dbe_evt && !(keep_first_err && addr_held_ff))
    begin
      // Take the address of this error
      nxt_dbe_addr = err_addr;
      nxt_addr_held = 1'b1;
    end

    // Piece pointers: new capture or clear restarts at the lowest piece
    // A read of a data word steps its pointer even if the answer is dropped
    if (sbe_evt || clear_sbe_data)
      nxt_sbe_ptr = '0;
    else if (rd_sbe_data)
      nxt_sbe_ptr = step_ptr(sbe_ptr_ff);
    else
      nxt_sbe_ptr = sbe_ptr_ff;
    if (dbe_evt || clear_dbe_data)
      nxt_dbe_ptr = '0;
    else if (rd_dbe_data)
      nxt_dbe_ptr = step_ptr(dbe_ptr_ff);
    else
      nxt_dbe_ptr = dbe_ptr_ff;

    // Write-only mask
    nxt_mask = wr_mask ? writedata[`IRQ_BITS-1:0] : mask_ff;

    // Interrupt when any unmasked status bit is set
    // Registered so the line only moves on clock edges
    nxt_irq = |(stat_q & ~mask_ff);

    // Read answer, one cycle after the read
    // Readdata holds the last answer until the next read
    nxt_rvalid = read;
    nxt_rdata = rdata_ff;
    if (read)
    begin
      unique case (address)
        `OFS_DBE_ADDR: nxt_rdata = dbe_addr_ff;
        `OFS_SBE_DATA: nxt_rdata = sbe_if.rdata;
        `OFS_SBE_SYND: nxt_rdata = widen(32'(syn_if.rdata), `SYND_BITS);
        `OFS_DBE_DATA: nxt_rdata = dbe_if.rdata;
        `OFS_IRQ_STAT: nxt_rdata = widen(32'(stat_q), `IRQ_BITS);
        `OFS_SBE_LOC: nxt_rdata = widen(32'(sloc_q), N);
        `OFS_DBE_LOC: nxt_rdata = widen(32'(dloc_q), N);
        // Mask is write-only, other words are not here
        default: nxt_rdata = `RST_WORD;
      endcase
    end
  end

  // Register the group
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbe_addr_ff <= `RST_WORD;
      addr_held_ff <= 1'b0;
      sbe_ptr_ff <= '0;
      dbe_ptr_ff <= '0;
      mask_ff <= `RST_IRQ_MASK;
      rdata_ff <= `RST_WORD;
      rvalid_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      dbe_addr_ff <= nxt_dbe_addr;
      addr_held_ff <= nxt_addr_held;
      sbe_ptr_ff <= nxt_sbe_ptr;
      dbe_ptr_ff <= nxt_dbe_ptr;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign readdata = rdata_ff;
  assign readdatavalid = rvalid_ff;
  assign irq = irq_ff;
endmodule // ecc_status_regs

// File: hw/sticky_bits.sv
// Sticky event bits, set by hardware and cleared by ones, set wins
`timescale 1ns/1ns
module sticky_bits #(
  parameter int W = 5
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Set and clear vectors
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Held bits
  output logic [W-1:0] q
);
  logic [W-1:0] bits_ff; // Held bits
  logic [W-1:0] nxt_bits; // Next held bits

  // Refuse an empty bit vector
  if (W < 1)
  begin : g_bad_width
    $error("sticky_bits: W must be at least 1");
  end

  // Clear only ones, a same-cycle set survives
  always_comb
  begin
    nxt_bits = (bits_ff & ~clr) | set;
  end

  // Register the bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bits_ff <= '0;
    else
      bits_ff <= nxt_bits;
  end

  assign q = bits_ff;
endmodule // sticky_bits

// File: hw/word_store.sv
// Small memory holding one captured line, read a word at a time
`timescale 1ns/1ns
module word_store #(
  parameter int WORDS = 4,
  parameter int WIDTH = 32
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Store port
  word_store_if.store sp
);
  // Storage and registered read word
  logic [WIDTH-1:0] mem_ff [WORDS];
  logic [WIDTH-1:0] nxt_mem [WORDS];
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;

  // Refuse an empty store
  if (WORDS < 1 || WIDTH < 1)
  begin : g_bad_size
    $error("word_store: WORDS and WIDTH must be at least 1");
  end

  // ****************************************
  // Next contents and read word
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      // Clear wins, a load replaces all words
      if (sp.clear)
        nxt_mem[i] = '0;
      else if (sp.load)
        nxt_mem[i] = sp.wdata[i*WIDTH +: WIDTH];
      else
        nxt_mem[i] = mem_ff[i];
    end
    nxt_rdata = nxt_mem[sp.idx];
  end

  // Register contents and read word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_ff[i] <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sp.rdata = rdata_ff;
endmodule // word_store

// File: hw/word_store_if.sv
// Signals between the status logic and one captured-word store
`timescale 1ns/1ns
interface word_store_if #(
  parameter int WORDS = 4,
  parameter int WIDTH = 32
);
  localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;
  logic load; // Capture a whole new line
  logic clear; // Zero the whole store
  logic [WORDS*WIDTH-1:0] wdata; // Line to capture, word 0 lowest
  logic [IW-1:0] idx; // Word to present next cycle
  logic [WIDTH-1:0] rdata; // Registered word at idx
  modport ctrl (output load, output clear, output wdata, output idx, input rdata);
  modport store (input load, input clear, input wdata, input idx, output rdata);
endinterface

// File: testbench/ctrl_master.sv
// Processor model driving the control slave port
`timescale 1ns/1ns
module ctrl_master (
  // Clock
  input wire logic clk,
  // Requests
  output ecc_status_pkg::reg_addr_t address,
  output logic read,
  output logic write,
  output ecc_status_pkg::word_t writedata
);
  import ecc_status_pkg::*;
  // Idle at time zero
  initial
  begin
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
  end
  // One request per cycle; idle lines toggle so stale values never match
  task automatic xfer(input logic r, input logic w, input reg_addr_t a, input word_t d);
    read <= r;
    write <= w;
    address <= (r | w) ? a : ~address;
    writedata <= w ? d : ~writedata;
    @(posedge clk);
  endtask
endmodule // ctrl_master

// File: testbench/ecc_status_props.sv
// Checker of the ECC status register block ports
`timescale 1ns/1ns
module ecc_status_props #(
  parameter int N = 2
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control port
  input wire ecc_status_pkg::reg_addr_t address,
  input wire logic read,
  input wire ecc_status_pkg::word_t readdata,
  input wire logic readdatavalid,
  // Events
  input wire logic clear_status,
  input wire logic err_valid,
  input wire logic [N-1:0] sbe_parts,
  input wire logic [N-1:0] dbe_parts,
  input wire logic sbe_limit_hit,
  input wire logic dbe_limit_hit
);
  import ecc_status_pkg::*;
  // ****
  // Port properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (read |=> readdatavalid)
    else $error("read not answered");
  rd_only_a: assert property (readdatavalid |-> $past(read))
    else $error("answer without read");
  mask_hidden_a: assert property (read && address == 4'hB |=> readdata == 32'h0)
    else $error("mask readable");
  addr_clear_a: assert property ($past(clear_status) && read && address == 4'h6
    |=> readdata == 32'h0)
    else $error("address not cleared");
  stat_width_a: assert property (read && address == 4'hA |=> readdata[31:5] == 27'h0)
    else $error("status too wide");
  stat_sbe_a: assert property (err_valid && |sbe_parts ##1 read && address == 4'hA
    |=> readdata[0])
    else $error("sbe status missing");
  stat_dbe_a: assert property (err_valid && |dbe_parts ##1 read && address == 4'hA
    |=> readdata[1])
    else $error("dbe status missing");
  stat_limit_a: assert property (sbe_limit_hit && dbe_limit_hit ##1 read && address == 4'hA
    |=> readdata[3:2] == 2'b11)
    else $error("limit status missing");
  sloc_set_a: assert property (err_valid && sbe_parts[0] ##1 read && address == 4'hC
    |=> readdata[0])
    else $error("sbe location missing");
  dloc_set_a: assert property (err_valid && dbe_parts[N-1] ##1 read && address == 4'hD
    |=> readdata[N-1])
    else $error("dbe location missing");
endmodule // ecc_status_props

// File: testbench/tb_top.sv
// Self-checking bench of the ECC status register block
`timescale 1ns/1ns
module tb_top;
  import ecc_status_pkg::*;
  logic clk, rst_n, rdv, irq, ev_v, rmw, kf, sl, dl;
  logic [4:0] cw; // Clear status, irq, sbe data, dbe data, syndrome
  reg_addr_t address;
  logic read, write;
  word_t wdata, rdata, ea;
  logic [127:0] dat, ed; // Expected and driven data line
  logic [15:0] syn, es;
  logic [1:0] sp, dp;
  word_t q[$]; // Expected read answers, oldest first
  reg_addr_t ra[9] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h3};
  int bad_count, num_checks, cyc, seed, i;
  ctrl_master m (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(wdata));
  ecc_status_regs #(.N(2)) uut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(wdata), .readdata(rdata),
    .readdatavalid(rdv), .keep_first_err(kf), .clear_status(cw[4]), .clear_irq(cw[3]),
    .clear_sbe_data(cw[2]), .clear_dbe_data(cw[1]), .clear_syndrome(cw[0]),
    .err_valid(ev_v), .err_addr(ea), .err_data(ed), .err_syndromes(es), .sbe_parts(sp),
    .dbe_parts(dp), .err_in_rmw(rmw), .sbe_limit_hit(sl), .dbe_limit_hit(dl), .irq(irq));
  // ****
  // Tasks
  // ****
  task automatic chk(input word_t e, input word_t g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Interrupt level, sampled mid-cycle where it is settled
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({31'h0, e}, {31'h0, irq});
    @(posedge clk);
  endtask
  task automatic close_out();
    // Answers still awaited count as mismatches
    bad_count += q.size();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input reg_addr_t a, input word_t e);
    q.push_back(e);
    m.xfer(1'b1, 1'b0, a, 32'h0);
  endtask
  task automatic wr(input reg_addr_t a, input word_t d);
    m.xfer(1'b0, 1'b1, a, d);
  endtask
  // One-cycle decoder report with random line and syndromes
  task automatic ev(input logic [1:0] s, input logic [1:0] d, input logic r,
    input logic [1:0] l, input word_t a);
    dat = {$random(seed), $random(seed), $random(seed), $random(seed)};
    syn = 16'($random(seed));
    ed <= dat;
    es <= syn;
    sp <= s;
    dp <= d;
    rmw <= r;
    ea <= a;
    ev_v <= |{s, d};
    sl <= l[0];
    dl <= l[1];
    m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    ev_v <= 1'b0;
    sl <= 1'b0;
    dl <= 1'b0;
  endtask
  task automatic cwp(input logic [4:0] b);
    cw <= b;
    m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    cw <= 5'h00;
  endtask
  // ****
  // Clock, watchdog and answer monitor
  // ****
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      close_out();
    end
  end
  always @(negedge clk)
    if (rdv === 1'b1 && q.size() > 0)
      chk(q.pop_front(), rdata);
  // ****
  // Main sequence
  // ****
  initial
  begin
    seed = 10;
    {rst_n, ev_v, rmw, kf, sl, dl, cw, sp, dp, ea, ed, es} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 32'h0);
    ev(2'b01, 2'b00, 1'b0, 2'b00, 32'h0000_0100);
    rd(4'hA, 32'h1);
    rd(4'hC, 32'h1);
    rd(4'hD, 32'h0);
    repeat (2) m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    chk_irq(1'b0);
    wr(4'hB, 32'h0);
    repeat (2) m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    chk_irq(1'b1);
    wr(4'hC, 32'h0);
    rd(4'hC, 32'h1);
    wr(4'hC, 32'h1);
    rd(4'hC, 32'h0);
    wr(4'hA, 32'h1F);
    repeat (2) m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    chk_irq(1'b0);
    ev(2'b01, 2'b00, 1'b0, 2'b00, 32'h0000_0200);
    rd(4'hC, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      rd(4'h8, {24'h0, syn[((i % 4) / 2) * 8 +: 8]});
      rd(4'h7, dat[(i % 4) * 32 +: 32]);
    end
    wr(4'hA, 32'h1F);
    kf <= 1'b1;
    ev(2'b00, 2'b10, 1'b1, 2'b00, 32'h0000_0300);
    rd(4'hD, 32'h2);
    rd(4'h9, dat[31:0]);
    rd(4'h9, dat[63:32]);
    ev(2'b00, 2'b10, 1'b0, 2'b00, 32'h0000_0400);
    rd(4'hA, 32'h12);
    rd(4'h6, 32'h0000_0300);
    cwp(5'h10);
    rd(4'h6, 32'h0);
    kf <= 1'b0;
    ev(2'b00, 2'b01, 1'b0, 2'b00, 32'h0000_0500);
    m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    ev(2'b00, 2'b01, 1'b0, 2'b00, 32'h0000_0600);
    rd(4'h6, 32'h0000_0600);
    cwp(5'h02);
    rd(4'h9, 32'h0);
    cwp(5'h04);
    rd(4'h7, 32'h0);
    cwp(5'h01);
    rd(4'h8, 32'h0);
    wr(4'hA, 32'h1F);
    ev(2'b00, 2'b00, 1'b0, 2'b11, 32'h0);
    rd(4'hA, 32'h0C);
    chk_irq(1'b1);
    cwp(5'h08);
    rd(4'hA, 32'h0);
    chk_irq(1'b0);
    repeat (3) m.xfer(1'b0, 1'b0, 4'h0, 32'h0);
    close_out();
  end
endmodule // tb_top
bind ecc_status_regs ecc_status_props #(.N(N)) chk_i (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .readdata(readdata), .readdatavalid(readdatavalid),
  .clear_status(clear_status), .err_valid(err_valid), .sbe_parts(sbe_parts),
  .dbe_parts(dbe_parts), .sbe_limit_hit(sbe_limit_hit), .dbe_limit_hit(dbe_limit_hit));
